// [design/area_check.sv]
// Combinational permission decision for one access against the area table
`default_nettype none
module area_check #(
    parameter int N = 4
) (
    input  wire area_prot_pkg::access_t          acc_i,
    input  wire logic [31:0]                     fetch_addr_i,
    input  wire area_prot_pkg::area_t [N-1:0]    areas_i,
    input  wire logic                            enable_i,
    input  wire logic [2:0]                      dflt_i,
    output logic                                 permit_o
);
    function automatic logic hit(input logic [31:0] a, input area_prot_pkg::area_t ar);
        hit = ar.attr[area_prot_pkg::ATTR_EN] && a >= ar.base && a <= ar.limit;
    endfunction

    function automatic logic allow(input logic [7:0] at, input area_prot_pkg::op_t op, input logic p);
        logic r;
        logic w;
        logic x;
        r = p ? at[area_prot_pkg::ATTR_PR] : at[area_prot_pkg::ATTR_UR];
        w = p ? at[area_prot_pkg::ATTR_PW] : at[area_prot_pkg::ATTR_UW];
        x = p ? at[area_prot_pkg::ATTR_PX] : at[area_prot_pkg::ATTR_UX];
        case (op)
            area_prot_pkg::OP_READ:   allow = r;
            area_prot_pkg::OP_WRITE:  allow = w;
            area_prot_pkg::OP_DELETE: allow = w;
            area_prot_pkg::OP_EXEC:   allow = x;
            default:                  allow = 1'b0;
        endcase
    endfunction

    always_comb begin
        logic found;
        logic src_ok;
        found    = 1'b0;
        src_ok   = 1'b1;
        permit_o = 1'b0;
        // Lowest area wins; target decides op, fetch source may restrict data use
        for (int i = N - 1; i >= 0; i--) begin
            if (hit(acc_i.addr, areas_i[i])) begin
                found    = 1'b1;
                permit_o = allow(areas_i[i].attr, acc_i.op, acc_i.priv);
                src_ok   = !areas_i[i].attr[area_prot_pkg::ATTR_XF] ||
                           hit(fetch_addr_i, areas_i[i]) || acc_i.op == area_prot_pkg::OP_EXEC;
            end
        end
        if (!found) begin
            permit_o = allow({2'b00, dflt_i, dflt_i}, acc_i.op, acc_i.priv);
        end
        permit_o = !enable_i || (permit_o && src_ok);
    end
endmodule
`default_nettype wire

// [design/area_protection_unit.sv]
// Area protection unit: access gate between core and memories, Wishbone control registers
`default_nettype none
// Overview of operation
// - Police read, write, delete and execute to memory; separate privileged and user mode.
// - Decide on fetch source area, target area and operation kind.
// - Evaluate permission before access; denied access never returns data or writes.
// - Hardware checks every access; permitted completes, denied has no memory effect.
// - Attribute changes accepted only from privileged software.
// - Every attribute has a defined default policy.
// - Defaults may be overridden at run time by software with the needed access.
// - Configuration is exposed as control registers of the unit.
module area_protection_unit #(
    parameter int N = area_prot_pkg::NUM_AREAS
) (
    input  wire  logic                   clk_i,
    input  wire  logic                   rst_i,
    // Core side
    input  wire  area_prot_pkg::access_t core_acc_i,
    input  wire  logic [31:0]            core_wdata_i,
    input  wire  logic [31:0]            fetch_addr_i,
    output logic                         core_ack_o,
    output logic                         core_fault_o,
    output logic [31:0]                  core_rdata_o,
    // Memory side
    output area_prot_pkg::access_t       mem_acc_o,
    output logic [31:0]                  mem_wdata_o,
    input  wire  logic                   mem_ack_i,
    input  wire  logic [31:0]            mem_rdata_i,
    // Wishbone slave
    input  wire  logic                   cyc_i,
    input  wire  logic                   stb_i,
    input  wire  logic                   we_i,
    input  wire  logic [7:0]             adr_i,
    input  wire  logic [3:0]             sel_i,
    input  wire  logic [31:0]            dat_i,
    output logic [31:0]                  dat_o,
    output logic                         ack_o,
    input  wire  logic                   bus_priv_i,
    output logic                         irq_o
);
    typedef enum {S_IDLE, S_MEM, S_DONE} st_t;

    area_prot_pkg::area_t [N-1:0] area_reg;
    logic        en_reg;
    logic [2:0]  dflt_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic [31:0] vaddr_reg;
    logic [3:0]  vinfo_reg;
    st_t         st_reg;
    logic        permit;

    // Permission decision for the access now offered by the core
    area_check #(.N(N)) u_check (
        .acc_i        (core_acc_i),
        .fetch_addr_i (fetch_addr_i),
        .areas_i      (area_reg),
        .enable_i     (en_reg),
        .dflt_i       (dflt_reg),
        .permit_o     (permit)
    );

    // Bus access decode
    wire logic bus_req = cyc_i && stb_i && !ack_o;
    wire logic bus_wr  = bus_req && we_i;
    wire logic cfg_ok  = bus_priv_i;
    wire logic cfg_wr  = bus_wr && cfg_ok;
    wire logic cfg_bad = bus_wr && !cfg_ok;
    // Write-one-to-clear mask for the status register
    wire logic [1:0] status_clr = (cfg_wr && adr_i == area_prot_pkg::OFF_STATUS && sel_i[0]) ?
                                  dat_i[1:0] : 2'h0;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                old[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = old;
    endfunction

    function automatic int area_idx(input logic [7:0] a);
        area_idx = (int'(a) - int'(area_prot_pkg::OFF_AREA0)) / area_prot_pkg::AREA_STEP;
    endfunction

    wire logic in_area = adr_i >= area_prot_pkg::OFF_AREA0 &&
                         area_idx(adr_i) < N;
    wire logic [3:0] area_off = adr_i[3:0];

    // Access gate
    wire logic start = st_reg == S_IDLE && core_acc_i.valid;
    wire logic deny  = start && !permit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg       <= S_IDLE;
            mem_acc_o    <= '0;
            mem_wdata_o  <= 32'h0000_0000;
            core_ack_o   <= 1'b0;
            core_fault_o <= 1'b0;
            core_rdata_o <= 32'h0000_0000;
        end else begin
            core_ack_o   <= 1'b0;
            core_fault_o <= 1'b0;
            case (st_reg)
                S_IDLE: begin
                    if (core_acc_i.valid) begin
                        if (permit) begin
                            mem_acc_o   <= core_acc_i;
                            mem_wdata_o <= core_wdata_i;
                            st_reg      <= S_MEM;
                        end else begin
                            core_ack_o   <= 1'b1;
                            core_fault_o <= 1'b1;
                            core_rdata_o <= 32'h0000_0000;
                            st_reg       <= S_DONE;
                        end
                    end
                end
                S_MEM: begin
                    if (mem_ack_i) begin
                        mem_acc_o    <= '0;
                        core_ack_o   <= 1'b1;
                        core_rdata_o <= mem_rdata_i;
                        st_reg       <= S_DONE;
                    end
                end
                S_DONE: begin
                    st_reg <= S_IDLE;
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // Violation capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vaddr_reg <= 32'h0000_0000;
            vinfo_reg <= 4'h0;
        end else if (deny) begin
            vaddr_reg <= core_acc_i.addr;
            vinfo_reg <= {core_acc_i.priv, 1'b0, core_acc_i.op};
        end
    end

    // Configuration registers, privileged writes only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_reg   <= area_prot_pkg::CTRL_EN_RESET;
            dflt_reg <= area_prot_pkg::DEFAULT_POLICY;
            mask_reg <= 2'h0;
            for (int i = 0; i < N; i++) begin
                area_reg[i].base  <= area_prot_pkg::BASE_RESET;
                area_reg[i].limit <= area_prot_pkg::LIMIT_RESET;
                area_reg[i].attr  <= area_prot_pkg::ATTR_RESET;
            end
        end else if (cfg_wr) begin
            if (adr_i == area_prot_pkg::OFF_CTRL) begin
                en_reg   <= sel_i[0] ? dat_i[0] : en_reg;
                dflt_reg <= sel_i[0] ? dat_i[3:1] : dflt_reg;
            end
            if (adr_i == area_prot_pkg::OFF_MASK && sel_i[0]) begin
                mask_reg <= dat_i[1:0];
            end
            if (in_area) begin
                case (area_off)
                    area_prot_pkg::AREA_BASE:
                        area_reg[area_idx(adr_i)].base <= merge(area_reg[area_idx(adr_i)].base, dat_i, sel_i);
                    area_prot_pkg::AREA_LIMIT:
                        area_reg[area_idx(adr_i)].limit <= merge(area_reg[area_idx(adr_i)].limit, dat_i, sel_i);
                    area_prot_pkg::AREA_ATTR:
                        if (sel_i[0]) begin
                            area_reg[area_idx(adr_i)].attr <= dat_i[7:0];
                        end
                    default: ;
                endcase
            end
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 2'h0;
        end else begin
            status_reg <= (status_reg & ~status_clr) | {cfg_bad, deny};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    // Wishbone answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= 32'h0000_0000;
            if (bus_req && !we_i) begin
                case (adr_i)
                    area_prot_pkg::OFF_CTRL:   dat_o <= {28'h0, dflt_reg, en_reg};
                    area_prot_pkg::OFF_STATUS: dat_o <= {30'h0, status_reg};
                    area_prot_pkg::OFF_MASK:   dat_o <= {30'h0, mask_reg};
                    area_prot_pkg::OFF_VADDR:  dat_o <= vaddr_reg;
                    area_prot_pkg::OFF_VINFO:  dat_o <= {28'h0, vinfo_reg};
                    default: begin
                        if (in_area) begin
                            case (area_off)
                                area_prot_pkg::AREA_BASE:  dat_o <= area_reg[area_idx(adr_i)].base;
                                area_prot_pkg::AREA_LIMIT: dat_o <= area_reg[area_idx(adr_i)].limit;
                                area_prot_pkg::AREA_ATTR:  dat_o <= {24'h0, area_reg[area_idx(adr_i)].attr};
                                default:                   dat_o <= 32'h0000_0000;
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // Access outcomes decided in the idle state
    sequence s_denied;
        st_reg == S_IDLE && core_acc_i.valid && !permit;
    endsequence

    sequence s_granted;
        st_reg == S_IDLE && core_acc_i.valid && permit;
    endsequence

    a_deny_fault: assert property (@(posedge clk_i) disable iff (rst_i)
        s_denied |=> core_ack_o && core_fault_o && core_rdata_o == 32'h0)
        else $error("denied access not faulted");
    a_deny_nomem: assert property (@(posedge clk_i) disable iff (rst_i)
        s_denied |=> !mem_acc_o.valid [*2])
        else $error("denied access reached memory");
    a_permit_fwd: assert property (@(posedge clk_i) disable iff (rst_i)
        start && permit |=> mem_acc_o.valid && mem_acc_o.addr == $past(core_acc_i.addr))
        else $error("permitted access not forwarded");
    a_deny_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        s_denied |=> status_reg[area_prot_pkg::ST_VIOL])
        else $error("violation flag not set");
    a_user_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && !bus_priv_i |=> $stable(area_reg) && $stable(en_reg) && $stable(dflt_reg))
        else $error("user write changed attributes");
    a_reset_default: assert property (@(posedge clk_i)
        rst_i |=> en_reg == area_prot_pkg::CTRL_EN_RESET && area_reg[0].attr == area_prot_pkg::ATTR_RESET)
        else $error("attributes not restored on reset");
    a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> ack_o ##1 !ack_o)
        else $error("bus ack timing wrong");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        |(status_reg & mask_reg) |=> irq_o)
        else $error("interrupt not raised");
    a_priv_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_wr && adr_i == area_prot_pkg::OFF_CTRL && sel_i[0] |=> en_reg == $past(dat_i[0]))
        else $error("privileged override lost");

    // Core-side and memory-side handshake
    a_grant_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_granted |=> mem_acc_o == $past(core_acc_i) && mem_wdata_o == $past(core_wdata_i))
        else $error("granted access not copied to memory side");
    a_mem_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_acc_o.valid && !mem_ack_i |=> mem_acc_o.valid && $stable(mem_acc_o))
        else $error("memory request changed before answer");
    a_mem_done: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_acc_o.valid && mem_ack_i |=> core_ack_o && !core_fault_o && !mem_acc_o.valid)
        else $error("memory answer not returned to core");
    a_fault_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        core_fault_o |-> core_ack_o)
        else $error("fault without acknowledge");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        core_ack_o |=> !core_ack_o)
        else $error("core acknowledge longer than one cycle");

    // Status, interrupt and bus
    a_vaddr_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        s_denied |=> vaddr_reg == $past(core_acc_i.addr))
        else $error("violation address not captured");
    a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        status_clr[area_prot_pkg::ST_VIOL] && !deny |=> !status_reg[area_prot_pkg::ST_VIOL])
        else $error("violation flag not cleared");
    a_cfg_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_bad |=> status_reg[area_prot_pkg::ST_CFG])
        else $error("unprivileged write not flagged");
    a_irq_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !(|(status_reg & mask_reg)) |=> !irq_o)
        else $error("interrupt without unmasked event");
    a_wb_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !cyc_i |=> !ack_o)
        else $error("bus ack without cycle");
endmodule
`default_nettype wire

// [dv/area_protection_unit_tb_top.sv]
// Self-checking bench for the area protection unit
`default_nettype none
module area_protection_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clk_i, rst_i, cyc_i, stb_i, we_i, bus_priv_i, ack_o, irq_o;
    logic                   core_ack_o, core_fault_o, mem_ack_i, fault, bp;
    area_prot_pkg::access_t core_acc_i, mem_acc_o;
    logic [31:0]            core_wdata_i, fetch_addr_i, core_rdata_o, mem_wdata_o, mem_rdata_i;
    logic [31:0]            dat_i, dat_o, rd, rdc;
    logic [7:0]             adr_i;
    logic [3:0]             sel_i, lat;
    int                     err_total, compares;

    area_protection_unit #(.N(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .core_acc_i(core_acc_i),
        .core_wdata_i(core_wdata_i), .fetch_addr_i(fetch_addr_i), .core_ack_o(core_ack_o),
        .core_fault_o(core_fault_o), .core_rdata_o(core_rdata_o), .mem_acc_o(mem_acc_o),
        .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .bus_priv_i(bus_priv_i), .irq_o(irq_o));
    mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .acc_i(mem_acc_o), .wdata_i(mem_wdata_o),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i, bus_priv_i} <= {1'b1, 1'b1, w, a, d, 4'hF, bp};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // One core access; a denied one must answer with fault and zero data
    task automatic acc(input int o, input logic [31:0] a, input logic p, input logic [31:0] wd,
                       input logic [31:0] fa, input logic ef);
        @(posedge clk_i);
        core_acc_i <= area_prot_pkg::access_t'{valid: 1'b1, addr: a, op: area_prot_pkg::op_t'(o), priv: p};
        core_wdata_i <= wd;
        fetch_addr_i <= fa;
        do begin
            @(posedge clk_i);
        end while (core_ack_o !== 1'b1);
        fault = core_fault_o;
        rdc = core_rdata_o;
        core_acc_i.valid <= 1'b0;
        chk({31'h0, fault}, {31'h0, ef});
        if (ef) chk(rdc, 32'h0);
    endtask

    initial begin
        #100000;
        err_total++;
        end_sim();
    end

    initial begin
        {rst_i, bp, cyc_i, stb_i, we_i, bus_priv_i} = 6'b110001;
        {adr_i, sel_i, dat_i, core_wdata_i, fetch_addr_i, lat} = '0;
        core_acc_i = '0;
        err_total = 0;
        compares = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h00, 32'h0000_000E);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rdchk(8'h20 + 8'(16 * i), 32'h0);
            rdchk(8'h24 + 8'(16 * i), 32'hFFFF_FFFF);
            rdchk(8'h28 + 8'(16 * i), 32'h38);
        end
        acc(1, 32'h10, 1'b0, 32'h1234_5678, 32'h0, 1'b0);
        acc(0, 32'h10, 1'b0, 32'h0, 32'h0, 1'b0);
        chk(rdc, 32'h1234_5678);
        bp = 1'b0;
        wr(8'h00, 32'h0F);
        bp = 1'b1;
        rdchk(8'h00, 32'h0000_000E);
        rdchk(8'h04, 32'h2);
        wr(8'h04, 32'h2);
        rdchk(8'h04, 32'h0);
        // Area 0 privileged only, area 1 user data tied to its own code
        wr(8'h24, 32'hFF);
        wr(8'h28, 32'hB8);
        wr(8'h30, 32'h100);
        wr(8'h34, 32'h1FF);
        wr(8'h38, 32'hC3);
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h0F);
        rdchk(8'h28, 32'hB8);
        acc(1, 32'h10, 1'b1, 32'hA5A5_A5A5, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) acc(i, 32'h10, 1'b0, 32'hDEAD_BEEF, 32'h0, 1'b1);
        rdchk(8'h04, 32'h1);
        rdchk(8'h0C, 32'h10);
        rdchk(8'h10, 32'h3);
        chk({31'h0, irq_o}, 32'h1);
        acc(0, 32'h10, 1'b1, 32'h0, 32'h0, 1'b0);
        chk(rdc, 32'hA5A5_A5A5);
        acc(2, 32'h10, 1'b1, 32'h0, 32'h0, 1'b0);
        wr(8'h04, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h08, 32'h0);
        acc(0, 32'h10, 1'b0, 32'h0, 32'h0, 1'b1);
        rdchk(8'h04, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h04, 32'h1);
        acc(1, 32'h104, 1'b0, 32'h0F0F_0F0F, 32'h110, 1'b0);
        acc(0, 32'h104, 1'b0, 32'h0, 32'h110, 1'b0);
        chk(rdc, 32'h0F0F_0F0F);
        acc(0, 32'h104, 1'b0, 32'h0, 32'h2000, 1'b1);
        acc(2, 32'h104, 1'b0, 32'h0, 32'h110, 1'b1);
        acc(0, 32'h1000, 1'b0, 32'h0, 32'h0, 1'b0);
        wr(8'h00, 32'h01);
        acc(0, 32'h1000, 1'b0, 32'h0, 32'h0, 1'b1);
        acc(1, 32'h1000, 1'b1, 32'h0, 32'h0, 1'b1);
        lat = 4'h5;
        acc(0, 32'h10, 1'b1, 32'h0, 32'h0, 1'b0);
        chk(rdc, 32'hA5A5_A5A5);
        rdchk(8'hFC, 32'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h00, 32'h0000_000E);
        rdchk(8'h28, 32'h38);
        end_sim();
    end
endmodule
`default_nettype wire

// [dv/mem_model.sv]
// Behavioural memory that answers forwarded accesses after a settable delay
`default_nettype none
module mem_model (
    input  wire  logic                   clk_i,
    input  wire  logic                   rst_i,
    input  wire  logic [3:0]             lat_i,
    input  wire  area_prot_pkg::access_t acc_i,
    input  wire  logic [31:0]            wdata_i,
    output logic                         ack_o,
    output logic [31:0]                  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem_reg [16];
    logic [3:0]  cnt_reg;
    // Read data toggles whenever no answer is given, so stale data never looks valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            cnt_reg <= 4'h0;
            rdata_o <= 32'h0;
        end else if (ack_o) begin
            ack_o   <= 1'b0;
            cnt_reg <= 4'h0;
            rdata_o <= ~rdata_o;
        end else if (acc_i.valid && cnt_reg == lat_i) begin
            ack_o   <= 1'b1;
            rdata_o <= mem_reg[acc_i.addr[5:2]];
            if (acc_i.op == area_prot_pkg::OP_WRITE || acc_i.op == area_prot_pkg::OP_DELETE) begin
                mem_reg[acc_i.addr[5:2]] <= wdata_i;
            end
        end else begin
            cnt_reg <= acc_i.valid ? cnt_reg + 4'h1 : 4'h0;
            rdata_o <= ~rdata_o;
        end
    end
endmodule
`default_nettype wire

// [include/area_prot_pkg.sv]
// Package: register map, attribute layout and access types of the area protection unit
`default_nettype none
package area_prot_pkg;
    localparam int NUM_AREAS = 4;
    localparam int AW        = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK   = 8'h08;
    localparam logic [7:0] OFF_VADDR  = 8'h0C;
    localparam logic [7:0] OFF_VINFO  = 8'h10;
    localparam logic [7:0] OFF_AREA0  = 8'h20;
    localparam int         AREA_STEP  = 16;

    // Word offsets inside one area block
    localparam logic [3:0] AREA_BASE  = 4'h0;
    localparam logic [3:0] AREA_LIMIT = 4'h4;
    localparam logic [3:0] AREA_ATTR  = 4'h8;

    // Attribute bit positions
    localparam int ATTR_UR  = 0;
    localparam int ATTR_UW  = 1;
    localparam int ATTR_UX  = 2;
    localparam int ATTR_PR  = 3;
    localparam int ATTR_PW  = 4;
    localparam int ATTR_PX  = 5;
    localparam int ATTR_XF  = 6;
    localparam int ATTR_EN  = 7;

    // Defaults: area attributes privileged everything, user nothing; areas disabled; default policy grants everything
    localparam logic [7:0]  ATTR_RESET      = 8'h38;
    localparam logic [31:0] BASE_RESET      = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RESET     = 32'hFFFF_FFFF;
    localparam logic [2:0]  DEFAULT_POLICY  = 3'h7;
    localparam logic        CTRL_EN_RESET   = 1'b0;

    // Status bits
    localparam int ST_VIOL = 0;
    localparam int ST_CFG  = 1;

    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_EXEC, OP_DELETE} op_t;

    typedef struct packed {
        logic          valid;
        logic [AW-1:0] addr;
        op_t           op;
        logic          priv;
    } access_t;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
        logic [7:0]  attr;
    } area_t;
endpackage
`default_nettype wire
